// ===== logic/bod_map.vh
/*
 * Address, field, opcode and response constants for the byte operand decoder.
 * Assumes inclusion by bare name from the logic/ directory.
 */
`ifndef BOD_MAP_VH
`define BOD_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, AXI4-Lite)
// ----------------------------------------------------------------
`define BOD_OFF_CTRL 4'h0
`define BOD_OFF_INSN 4'h4
`define BOD_OFF_WREG 4'h8
`define BOD_OFF_STAT 4'hC
`define BOD_AW 4

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define BOD_CTRL_XINST 0
`define BOD_CTRL_BANK_LO 8
`define BOD_CTRL_BANK_HI 11

// ----------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------
`define BOD_INSN_F_HI 7
`define BOD_INSN_F_LO 0
`define BOD_INSN_A 8
`define BOD_INSN_D 9
`define BOD_INSN_OP_HI 15
`define BOD_INSN_OP_LO 10
`define BOD_OP_SWAP 6'h0E
`define BOD_OP_SUBB 6'h0F
`define BOD_OP_MOVF 6'h14

// ----------------------------------------------------------------
// Addressing, bus response and data constants
// ----------------------------------------------------------------
`define BOD_IDX_LIMIT 8'h5F
`define BOD_ACC_SPLIT 8'h60
`define BOD_ACC_HI_BANK 4'hF
`define BOD_BANK_ZERO 4'h0
`define BOD_RESP_OKAY 2'h0
`define BOD_RESP_SLVERR 2'h2
`define BOD_WORDS 1
`define BOD_BYTE_ZERO 8'h00

`endif

// ===== logic/bod_file_ram.v
/*
 * File register memory: 4096 bytes, one read port, one write port.
 * Assumes write and read addresses are stable in the same clock domain.
 */
module bod_file_ram (
    input wire aclk,
    input wire ce,
    input wire [11:0] raddr,
    output wire [7:0] rdata,
    input wire we,
    input wire [11:0] waddr,
    input wire [7:0] wdata
);
    reg [7:0] mem [0:4095];

    // Asynchronous read lets Q2 see the operand in the same phase
    assign rdata = mem[raddr];

    // Write port used in Q4
    always @(posedge aclk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end
endmodule // bod_file_ram

// ===== logic/bod_decode.v
/*
 * Byte-oriented file-register instruction decoder with four-phase
 * execution, register file and AXI4-Lite control slave.
 * Assumes one clock, synchronous active-low reset, AXI4-Lite master.
 */
// How it works
// - d=1 writes result back to file register
// - d=0 writes result to working register only
// - a=0 uses access bank unless indexed (below), ignores bank pointer
// - a=1 uses bank pointer register for bank
// - extended set, a=0, f<=5Fh uses indexed offset
// - one word, one cycle of four phases
// - nibble swap exchanges upper and lower nibbles
`include "bod_map.vh"
module bod_decode (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [11:0] index_base,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output wire busy
);
    // ------------------------------------------------------------
    // Phase states
    // ------------------------------------------------------------
    // One-hot phase codes; idle sits between instructions
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_Q1 = 5'h02;
    localparam [4:0] ST_Q2 = 5'h04;
    localparam [4:0] ST_Q3 = 5'h08;
    localparam [4:0] ST_Q4 = 5'h10;

    // Sequencer state
    reg [4:0] state;
    reg [4:0] next_state;
    // Software-visible registers
    reg xinst;
    reg [3:0] bank_pointer_register;
    reg [15:0] insn;
    reg [7:0] wreg;
    // Execution datapath
    reg [7:0] operand;
    reg [7:0] result;
    reg [11:0] eff_addr;
    reg [1:0] mode_last;
    reg [15:0] done_count;
    // Bus capture
    reg [31:0] wdata_q;
    reg [3:0] awaddr_q;
    reg [3:0] wstrb_q;
    reg aw_held;
    reg w_held;
    reg go;
    // Decode results
    wire [7:0] ram_rdata;
    wire [11:0] next_addr;
    wire [1:0] next_mode;
    wire wr_fire;
    wire [31:0] stat_word;

    // Effective address: returns {mode, address}; mode 0 bank,
    // 1 access, 2 indexed
    function [13:0] bod_resolve;
        input [7:0] f;
        input a;
        input x;
        input [3:0] bank;
        input [11:0] base;
        begin
            // Banked first, then indexed, then the access bank
            if (a) begin
                bod_resolve = {2'h0, bank, f};
            end else if (x && (f <= `BOD_IDX_LIMIT)) begin
                bod_resolve = {2'h2, base + {4'h0, f}};
            end else if (f < `BOD_ACC_SPLIT) begin
                bod_resolve = {2'h1, `BOD_BANK_ZERO, f};
            end else begin
                // Upper access bank; also the fallback
                bod_resolve = {2'h1, `BOD_ACC_HI_BANK, f};
            end
        end
    endfunction

    // Strobe-merge of one byte lane
    function [7:0] bod_lane;
        input [7:0] old;
        input [7:0] neu;
        input en;
        begin
            bod_lane = en ? neu : old;
        end
    endfunction

    // Word index of a bus address; the two low bits are ignored,
    // so every address inside a word reaches that word's register
    function [3:0] bod_word;
        input [3:0] addr;
        begin
            bod_word = {addr[3:2], 2'h0};
        end
    endfunction

    // Address for the current word, latched in Q1
    assign {next_mode, next_addr} = bod_resolve(
        insn[`BOD_INSN_F_HI:`BOD_INSN_F_LO], insn[`BOD_INSN_A],
        xinst, bank_pointer_register, index_base);

    // ------------------------------------------------------------
    // File register memory
    // ------------------------------------------------------------
    // One access per phase: read in Q2, write back in Q4, both at
    // the address latched in Q1
    bod_file_ram u_ram (
        .aclk(aclk),
        .ce(ce),
        .raddr(eff_addr),
        .rdata(ram_rdata),
        .we((state == ST_Q4) && insn[`BOD_INSN_D]),
        .waddr(eff_addr),
        .wdata(result)
    );

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Readies follow the clock enable, so no beat is accepted while
    // the capture registers are frozen and would lose it
    assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_held && !s_axi_bvalid;
    assign s_axi_arready = ce && !s_axi_rvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign busy = (state != ST_IDLE);
    assign stat_word = {done_count, 6'h00, mode_last, 7'h00, busy};

    // Capture address and data in either order
    // An outstanding response blocks new beats
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BOD_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (bod_word(awaddr_q))
                    `BOD_OFF_CTRL, `BOD_OFF_INSN, `BOD_OFF_WREG:
                        s_axi_bresp <= `BOD_RESP_OKAY;
                    default: s_axi_bresp <= `BOD_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `BOD_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `BOD_RESP_OKAY;
                // All four words are mapped; the default only guards
                // against a wider address field
                case (bod_word(s_axi_araddr))
                    `BOD_OFF_CTRL: s_axi_rdata <= {20'h00000,
                        bank_pointer_register, 7'h00, xinst};
                    `BOD_OFF_INSN: s_axi_rdata <= {16'h0000, insn};
                    `BOD_OFF_WREG: s_axi_rdata <= {24'h000000, wreg};
                    `BOD_OFF_STAT: s_axi_rdata <= stat_word;
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `BOD_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Register writes; an instruction write starts execution
    // An instruction write while busy is answered but dropped
    always @(posedge aclk) begin
        if (!aresetn) begin
            xinst <= 1'b0;
            bank_pointer_register <= `BOD_BANK_ZERO;
            insn <= 16'h0000;
            go <= 1'b0;
        end else if (ce) begin
            go <= 1'b0;
            if (wr_fire && (bod_word(awaddr_q) == `BOD_OFF_CTRL)) begin
                if (wstrb_q[0]) begin
                    xinst <= wdata_q[`BOD_CTRL_XINST];
                end
                if (wstrb_q[1]) begin
                    bank_pointer_register <=
                        wdata_q[`BOD_CTRL_BANK_HI:`BOD_CTRL_BANK_LO];
                end
            end
            if (wr_fire && (bod_word(awaddr_q) == `BOD_OFF_INSN)
                && !busy) begin
                insn[7:0] <= bod_lane(insn[7:0], wdata_q[7:0],
                    wstrb_q[0]);
                insn[15:8] <= bod_lane(insn[15:8], wdata_q[15:8],
                    wstrb_q[1]);
                go <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Four-phase sequencer
    // ------------------------------------------------------------
    // Idle waits for the start strobe; each phase lasts one enabled
    // clock, so an instruction spans four of them
    always @* begin
        case (state)
            ST_IDLE: next_state = go ? ST_Q1 : ST_IDLE;
            ST_Q1: next_state = ST_Q2;
            ST_Q2: next_state = ST_Q3;
            ST_Q3: next_state = ST_Q4;
            ST_Q4: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // Process step: swap nibbles, subtract with borrow, or move
    // No carry flag is kept, so the subtract ignores the borrow
    always @* begin
        case (insn[`BOD_INSN_OP_HI:`BOD_INSN_OP_LO])
            `BOD_OP_SWAP: result = {operand[3:0], operand[7:4]};
            `BOD_OP_SUBB: result = operand - wreg;
            default: result = operand;
        endcase
    end

    // Q1 decode, Q2 read, Q3 process, Q4 write destination
    // With ce low every phase register holds, so a phase stretches
    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            eff_addr <= 12'h000;
            operand <= `BOD_BYTE_ZERO;
            wreg <= `BOD_BYTE_ZERO;
            mode_last <= 2'h0;
            done_count <= 16'h0000;
        end else if (ce) begin
            state <= next_state;
            if (state == ST_Q1) begin
                eff_addr <= next_addr;
                mode_last <= next_mode;
            end
            if (state == ST_Q2) begin
                operand <= ram_rdata;
            end
            if (state == ST_Q4) begin
                if (!insn[`BOD_INSN_D]) begin
                    wreg <= result;
                end
                done_count <= done_count + 16'h0001;
            end
            // A bus write to the working register lands only when idle
            if (wr_fire && (bod_word(awaddr_q) == `BOD_OFF_WREG)
                && wstrb_q[0] && !busy) begin
                wreg <= wdata_q[7:0];
            end
        end
    end
endmodule // bod_decode

// ===== verification/bod_decode_assertions.sv
/*
 * Port-level checker for the byte operand decoder.
 * Assumes it is bound to bod_decode, one clock, active-low reset.
 */
`include "bod_map.vh"
module bod_decode_chk (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire busy,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    // A frozen clock enable cuts every pending attempt
    default disable iff (!aresetn || !ce);
    // Both write halves taken at one edge
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Instruction word written while idle, all bytes
    sequence insn_go;
        wr_take ##0 (s_axi_awaddr == `BOD_OFF_INSN && !busy
            && s_axi_wstrb == 4'hF);
    endsequence
    // Four phases, then idle
    sequence busy_run;
        busy [*4] ##1 !busy;
    endsequence
    busy_len_a: assert property ($rose(busy) |-> busy_run)
        else $error("busy did not last four cycles");
    insn_start_a: assert property (insn_go |-> ##3 busy)
        else $error("instruction did not start");
    wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response late");
    b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready
        && !s_axi_wready) else $error("write taken during response");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read response late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    stat_err_a: assert property (wr_take ##0 s_axi_awaddr == `BOD_OFF_STAT
        |-> ##2 s_axi_bresp == `BOD_RESP_SLVERR)
        else $error("status write ok");
    err_zero_a: assert property (s_axi_rvalid
        && s_axi_rresp == `BOD_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read with data");
endmodule // bod_decode_chk

bind bod_decode bod_decode_chk u_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .busy(busy), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid));

// ===== verification/tb_top.sv
/*
 * Self-checking bench for the byte operand decoder over AXI4-Lite.
 * Assumes file memory starts cleared and the map header is reachable.
 */
`include "bod_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] index_base;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata;
    wire awready, wready, bvalid, arready, rvalid, busy;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer fail_count = 0, tests_run = 0, cyc = 0, i;

    bod_decode u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .index_base(index_base), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .busy(busy));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Compare one word
    task chk(input [31:0] g, input [31:0] e);
        tests_run++;
        if (g !== e) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            fail_count++;
        end
    endtask
    // Write one word, address and data offered together
    task wr(input [3:0] a, input [31:0] d, input [1:0] er);
        reg got;
        got = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!got) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) begin
                bready <= 0;
                got = 1;
                chk({30'h0, bresp}, {30'h0, er});
            end
        end
    endtask
    // Read one word and compare data and response
    task rd(input [3:0] a, input [31:0] e, input [1:0] er);
        reg got;
        got = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        while (!got) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) begin
                rready <= 0;
                got = 1;
                chk(rdata, e);
                chk({30'h0, rresp}, {30'h0, er});
            end
        end
    endtask
    // Run one instruction, then wait six cycles after the response
    task ex(input [5:0] op, input d, input a, input [7:0] f);
        wr(`BOD_OFF_INSN, {16'h0, op, d, a, f}, 2'h0);
        repeat (6) @(posedge aclk);
    endtask
    // Counts, verdict, end of run
    task complete_run;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        aclk = 0;
        forever #10 aclk = ~aclk;
    end
    // Cuts a hang short
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            complete_run;
        end
    end
    // Each step checks a bus response, a register readback or the busy flag
    initial begin
        aresetn = 0; ce = 1; index_base = 12'h000; awvalid = 0;
        wvalid = 0; bready = 0; arvalid = 0; rready = 0; awaddr = 4'h0;
        araddr = 4'h0; wstrb = 4'hF; wdata = 32'h0;
        // Clear the file memory, which has no reset of its own
        for (i = 0; i < 4096; i = i + 1)
            u_dut.u_ram.mem[i] = 8'h00;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        rd(`BOD_OFF_CTRL, 32'h0, 2'h0);
        rd(`BOD_OFF_INSN, 32'h0, 2'h0);
        rd(`BOD_OFF_WREG, 32'h0, 2'h0);
        rd(`BOD_OFF_STAT, 32'h0, 2'h0);
        rd(4'h2, 32'h0, 2'h0);
        wr(`BOD_OFF_STAT, 32'h1, `BOD_RESP_SLVERR);
        wr(`BOD_OFF_CTRL, 32'h0300, 2'h0);
        wr(`BOD_OFF_WREG, 32'h05, 2'h0);
        ex(`BOD_OP_SUBB, 1, 1, 8'h10);
        rd(`BOD_OFF_WREG, 32'h05, 2'h0);
        ex(`BOD_OP_MOVF, 0, 1, 8'h10);
        rd(`BOD_OFF_WREG, 32'hFB, 2'h0);
        ex(`BOD_OP_MOVF, 0, 0, 8'h10);
        rd(`BOD_OFF_WREG, 32'h00, 2'h0);
        rd(`BOD_OFF_STAT, 32'h0003_0100, 2'h0);
        wr(`BOD_OFF_WREG, 32'h05, 2'h0);
        ex(`BOD_OP_SUBB, 0, 1, 8'h10);
        rd(`BOD_OFF_WREG, 32'hF6, 2'h0);
        ex(`BOD_OP_MOVF, 0, 1, 8'h10);
        rd(`BOD_OFF_WREG, 32'hFB, 2'h0);
        ex(`BOD_OP_SWAP, 1, 1, 8'h10);
        ex(`BOD_OP_MOVF, 0, 1, 8'h10);
        rd(`BOD_OFF_WREG, 32'hBF, 2'h0);
        index_base <= 12'h2B1;
        wr(`BOD_OFF_CTRL, 32'h1, 2'h0);
        ex(`BOD_OP_MOVF, 0, 0, 8'h5F);
        rd(`BOD_OFF_WREG, 32'hBF, 2'h0);
        rd(`BOD_OFF_STAT, 32'h0008_0200, 2'h0);
        index_base <= 12'h2B0;
        ex(`BOD_OP_MOVF, 0, 0, 8'h60);
        rd(`BOD_OFF_WREG, 32'h00, 2'h0);
        rd(`BOD_OFF_STAT, 32'h0009_0100, 2'h0);
        // Clock enable low in Q1 must hold the instruction in flight
        wr(`BOD_OFF_WREG, 32'h5A, 2'h0);
        wr(`BOD_OFF_INSN, {16'h0, `BOD_OP_MOVF, 1'b0, 1'b0, 8'h60}, 2'h0);
        ce <= 0;
        repeat (5) @(posedge aclk);
        chk({31'h0, busy}, 32'h1);
        ce <= 1;
        repeat (6) @(posedge aclk);
        rd(`BOD_OFF_WREG, 32'h00, 2'h0);
        rd(`BOD_OFF_STAT, 32'h000A_0100, 2'h0);
        complete_run;
    end
endmodule // tb_top
